// file: verilog/dma_setup_regs.svh
// Register offsets, field positions, reset values and step sizes of the DMA channel setup block
`ifndef DMA_SETUP_REGS_SVH
`define DMA_SETUP_REGS_SVH

// Per-channel word index inside a channel window of eight words
`define DMA_CH_WINDOW_BITS 3
`define DMA_OFS_CONTROL 3'h0
`define DMA_OFS_REQ_SELECT 3'h1
`define DMA_OFS_PRIMARY_START 3'h2
`define DMA_OFS_SECONDARY_START 3'h3
`define DMA_OFS_PERIPH_ADDR 3'h4
`define DMA_OFS_XFER_COUNT 3'h5
// Shared collision status word, above the eight channel windows
`define DMA_ADDR_COLLISION_STATUS 7'h40

// Control register fields
`define DMA_CON_ENABLE_BIT 15
`define DMA_CON_BYTE_BIT 14
`define DMA_CON_DIR_BIT 13
`define DMA_CON_MODE_LSB 0
`define DMA_CON_WRITE_MASK 16'hf833
`define DMA_CON_RESET 16'h0000

// Request select fields
`define DMA_REQ_FORCE_BIT 15
`define DMA_REQ_SEL_MSB 6
`define DMA_REQ_RESET 7'h00

// Transfer count field
`define DMA_CNT_MSB 9
`define DMA_CNT_RESET 10'h000

// Address registers and status reset values
`define DMA_ADDR_RESET 16'h0000
`define DMA_STATUS_RESET 8'h00

// Pointer advance per word and per byte transfer
`define DMA_STEP_WORD 16'h0002
`define DMA_STEP_BYTE 16'h0001

`endif

// file: verilog/dma_setup_pkg.sv
// Types shared by the DMA channel setup block
`default_nettype none
package dma_setup_pkg;
    // Engine sequencing
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_LOAD = 1'b1
    } engine_state_e;

    // Operating mode: bit 0 one-shot, bit 1 alternating buffers
    typedef enum logic [1:0] {
        MODE_CONT = 2'b00,
        MODE_ONESHOT = 2'b01,
        MODE_CONT_ALT = 2'b10,
        MODE_ONESHOT_ALT = 2'b11
    } op_mode_e;

    typedef logic [15:0] word_t;
    typedef logic [2:0] chan_t;
endpackage
`default_nettype wire

// file: verilog/start_addr_mem.sv
// Small memory holding primary and secondary start addresses of all channels
`timescale 1ns/1ps
`default_nettype none
module start_addr_mem #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o
);
    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    // Array itself has no reset, so it maps onto plain storage
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read port, old data on a same-cycle write
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem_reg[rd_addr_i];
        end
    end
endmodule // start_addr_mem
`default_nettype wire

// file: verilog/dma_channel_setup_regs.sv
// Eight-channel DMA setup registers, trigger selection, pointer engine and collision status
// Operation
// [RULE1] Force bit makes exactly one transfer
// [RULE2] Force bit cleared only by hardware
// [RULE3] Without force, start on request edge
// [RULE4] Seven-bit code picks one of 128 lines
// [RULE5] Start address reads return live pointer
// [RULE6] Primary start address gives buffer location
// [RULE7] Secondary start address gives alternate buffer
// [RULE8] Peripheral address register drives peripheral side
// [RULE9] Block length is count plus one
// [RULE10] Unused request and count bits read zero
// [RULE11] Software avoids rewriting setup while enabled
// [RULE12] Peripheral collision flags in upper byte
// [RULE13] RAM collision flags in lower byte
// [RULE14] Collision flags sticky, reset zero, clearable
// [RULE15] Enable bit activates or stops channel
// [RULE16] Direction bit picks source and destination
// [RULE17] Two-bit mode: one-shot, continuous, alternating
// [RULE18] Block end pulses and reloads pointer
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dma_setup_regs.svh"
module dma_channel_setup_regs
    import dma_setup_pkg::*;
#(
    parameter int NUM_CH = 8,
    parameter int NUM_SRC = 128
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic [NUM_SRC-1:0] source_request_lines_i,
    input wire logic [NUM_CH-1:0] periph_collision_i,
    input wire logic [NUM_CH-1:0] ram_collision_i,
    output logic xfer_valid_o,
    output logic [2:0] xfer_chan_o,
    output logic [15:0] xfer_ram_addr_o,
    output logic [15:0] xfer_periph_addr_o,
    output logic xfer_ram_to_periph_o,
    output logic xfer_byte_o,
    output logic [NUM_CH-1:0] block_done_o
);
    // Lowest-numbered set bit wins; used for loads and for transfers
    function automatic chan_t first_set(input logic [7:0] vec);
        chan_t idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (vec[i]) begin
                idx = i[2:0];
            end
        end
        return idx;
    endfunction

    // Per-channel state
    word_t con_reg [NUM_CH];
    logic [6:0] req_sel_reg [NUM_CH];
    logic [NUM_CH-1:0] force_reg;
    word_t pad_reg [NUM_CH];
    logic [9:0] cnt_reg [NUM_CH];
    word_t ptr_reg [NUM_CH];
    logic [9:0] done_reg [NUM_CH];
    logic [NUM_CH-1:0] alt_sel_reg;
    logic [NUM_CH-1:0] need_load_reg;
    logic [NUM_CH-1:0] pend_reg;
    logic [NUM_CH-1:0] src_prev_reg;
    logic [7:0] pcol_reg;
    logic [7:0] xcol_reg;
    engine_state_e state_reg;
    engine_state_e state_next;
    chan_t load_ch_reg;
    // Set when a load's memory read raced a write to the same channel
    logic load_stale_reg;

    // Bus decode
    wire logic [2:0] bus_ch = reg_addr_i[5:3];
    wire logic [2:0] bus_ofs = reg_addr_i[2:0];
    wire logic in_ch_space = (reg_addr_i[6] == 1'b0);
    wire logic wr_status = reg_wr_i && (reg_addr_i == `DMA_ADDR_COLLISION_STATUS);
    wire logic wr_con = reg_wr_i && in_ch_space && (bus_ofs == `DMA_OFS_CONTROL);
    wire logic wr_req = reg_wr_i && in_ch_space && (bus_ofs == `DMA_OFS_REQ_SELECT);
    wire logic wr_sta = reg_wr_i && in_ch_space && (bus_ofs == `DMA_OFS_PRIMARY_START);
    wire logic wr_stb = reg_wr_i && in_ch_space && (bus_ofs == `DMA_OFS_SECONDARY_START);
    wire logic wr_pad = reg_wr_i && in_ch_space && (bus_ofs == `DMA_OFS_PERIPH_ADDR);
    wire logic wr_cnt = reg_wr_i && in_ch_space && (bus_ofs == `DMA_OFS_XFER_COUNT);

    // Channel trigger selection and request edges
    logic [NUM_CH-1:0] chan_on;
    logic [NUM_CH-1:0] trig_level;
    logic [NUM_CH-1:0] trig_edge;
    logic [NUM_CH-1:0] ready_vec;
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            chan_on[c] = con_reg[c][`DMA_CON_ENABLE_BIT]; // RULE15
            trig_level[c] = source_request_lines_i[req_sel_reg[c]]; // RULE4
            trig_edge[c] = trig_level[c] && !src_prev_reg[c]; // RULE3
            ready_vec[c] = chan_on[c] && (pend_reg[c] || force_reg[c]) && !need_load_reg[c];
        end
    end

    // Engine choice: pending pointer loads beat transfers
    wire logic any_load = |need_load_reg;
    wire chan_t load_pick = first_set(need_load_reg);
    wire logic do_xfer = (state_reg == ST_IDLE) && !any_load && (|ready_vec);
    wire chan_t xfer_ch = first_set(ready_vec);
    wire logic do_load = (state_reg == ST_IDLE) && any_load;
    wire logic load_fin = (state_reg == ST_LOAD);

    // Start address memory: index is channel and buffer select
    wire logic mem_wr = wr_sta || wr_stb;
    wire logic [3:0] mem_waddr = {bus_ch, wr_stb};
    wire logic [3:0] mem_raddr = {load_pick, alt_sel_reg[load_pick]};
    // A write to the channel being read leaves that registered read stale
    wire logic load_clash = (mem_wr || wr_con) && (bus_ch == load_pick);
    word_t mem_rdata;

    start_addr_mem #(
        .ADDR_W(4),
        .DATA_W(16)
    ) u_start_mem (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .wr_en_i(mem_wr), // RULE6 RULE7
        .wr_addr_i(mem_waddr),
        .wr_data_i(reg_wdata_i),
        .rd_addr_i(mem_raddr),
        .rd_data_o(mem_rdata)
    );

    // Transfer bookkeeping for the serviced channel
    wire word_t cur_con = con_reg[xfer_ch];
    wire logic [1:0] cur_mode = cur_con[`DMA_CON_MODE_LSB +: 2];
    wire logic blk_end = (done_reg[xfer_ch] == cnt_reg[xfer_ch]); // RULE9
    wire logic mode_alt = cur_mode[1];
    wire logic mode_oneshot = cur_mode[0];
    wire logic stop_after = mode_oneshot && (!mode_alt || alt_sel_reg[xfer_ch]);
    wire word_t step = cur_con[`DMA_CON_BYTE_BIT] ? `DMA_STEP_BYTE : `DMA_STEP_WORD;

    // Engine state
    always_comb begin
        case (state_reg)
            ST_IDLE: state_next = do_load ? ST_LOAD : ST_IDLE;
            ST_LOAD: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
            load_ch_reg <= 3'h0;
            load_stale_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            load_stale_reg <= 1'b0;
            if (do_load) begin
                load_ch_reg <= load_pick;
                load_stale_reg <= load_clash;
            end
        end
    end

    // Software-visible setup registers and channel progress
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                con_reg[c] <= `DMA_CON_RESET;
                done_reg[c] <= `DMA_CNT_RESET;
            end
            alt_sel_reg <= '0;
            need_load_reg <= '0;
            pend_reg <= '0;
        end else begin
            // Service first, so a new edge or write in the same cycle wins
            if (do_xfer) begin
                pend_reg[xfer_ch] <= 1'b0;
                done_reg[xfer_ch] <= done_reg[xfer_ch] + 10'h001;
                if (blk_end) begin
                    done_reg[xfer_ch] <= `DMA_CNT_RESET; // RULE18
                    need_load_reg[xfer_ch] <= 1'b1; // RULE18
                    alt_sel_reg[xfer_ch] <= mode_alt && !alt_sel_reg[xfer_ch]; // RULE17
                    if (stop_after) begin
                        con_reg[xfer_ch][`DMA_CON_ENABLE_BIT] <= 1'b0; // RULE17
                    end
                end
            end
            if (load_fin) begin
                // A clashing write during the load asks for one more load
                need_load_reg[load_ch_reg] <= load_stale_reg;
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (chan_on[c] && trig_edge[c]) begin
                    pend_reg[c] <= 1'b1; // RULE3
                end
            end
            if (wr_con) begin
                con_reg[bus_ch] <= reg_wdata_i & `DMA_CON_WRITE_MASK;
                if (reg_wdata_i[`DMA_CON_ENABLE_BIT] && !chan_on[bus_ch]) begin
                    // Fresh enable restarts at the primary buffer
                    alt_sel_reg[bus_ch] <= 1'b0;
                    done_reg[bus_ch] <= `DMA_CNT_RESET;
                    need_load_reg[bus_ch] <= 1'b1;
                    pend_reg[bus_ch] <= 1'b0;
                end
            end
            if (mem_wr) begin
                need_load_reg[bus_ch] <= 1'b1; // RULE5
            end
        end
    end

    // Plain setup words: only software writes them, the engine just reads
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                req_sel_reg[c] <= `DMA_REQ_RESET;
                pad_reg[c] <= `DMA_ADDR_RESET;
                cnt_reg[c] <= `DMA_CNT_RESET;
            end
        end else begin
            if (wr_req) begin
                req_sel_reg[bus_ch] <= reg_wdata_i[`DMA_REQ_SEL_MSB:0]; // RULE4 RULE10
            end
            if (wr_pad) begin
                pad_reg[bus_ch] <= reg_wdata_i; // RULE8
            end
            if (wr_cnt) begin
                cnt_reg[bus_ch] <= reg_wdata_i[`DMA_CNT_MSB:0]; // RULE9 RULE10
            end
        end
    end

    // Force flag: writes can only set it, its own transfer clears it
    // Set placed last, so a new force beside a finishing one is not lost
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            force_reg <= '0;
        end else begin
            if (do_xfer) begin
                force_reg[xfer_ch] <= 1'b0; // RULE1 RULE2
            end
            if (wr_req && reg_wdata_i[`DMA_REQ_FORCE_BIT]) begin
                force_reg[bus_ch] <= 1'b1; // RULE1 RULE2
            end
        end
    end

    // Live buffer pointer: steps per transfer, reloads from the start memory
    // No overlap: a channel awaiting a load is never picked for transfer
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                ptr_reg[c] <= `DMA_ADDR_RESET;
            end
        end else begin
            if (do_xfer) begin
                ptr_reg[xfer_ch] <= ptr_reg[xfer_ch] + step;
            end
            if (load_fin) begin
                ptr_reg[load_ch_reg] <= mem_rdata; // RULE18
            end
        end
    end

    // Line history runs while disabled, so enabling never sees a stale edge
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            src_prev_reg <= '0;
        end else begin
            src_prev_reg <= trig_level;
        end
    end

    // Collision flags: writing zero clears, a new event in that cycle wins
    wire logic [7:0] pcol_next = (wr_status ? (pcol_reg & reg_wdata_i[15:8]) : pcol_reg)
        | periph_collision_i; // RULE12 RULE14
    wire logic [7:0] xcol_next = (wr_status ? (xcol_reg & reg_wdata_i[7:0]) : xcol_reg)
        | ram_collision_i; // RULE13 RULE14
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pcol_reg <= `DMA_STATUS_RESET;
            xcol_reg <= `DMA_STATUS_RESET;
        end else begin
            pcol_reg <= pcol_next;
            xcol_reg <= xcol_next;
        end
    end

    // Read mux; start address slots show the live pointer
    word_t rd_word;
    always_comb begin
        rd_word = 16'h0000;
        if (reg_addr_i == `DMA_ADDR_COLLISION_STATUS) begin
            rd_word = {pcol_reg, xcol_reg}; // RULE12 RULE13
        end else if (in_ch_space) begin
            case (bus_ofs)
                `DMA_OFS_CONTROL: rd_word = con_reg[bus_ch];
                `DMA_OFS_REQ_SELECT: rd_word = {force_reg[bus_ch], 8'h00, req_sel_reg[bus_ch]}; // RULE10
                `DMA_OFS_PRIMARY_START: rd_word = ptr_reg[bus_ch]; // RULE5
                `DMA_OFS_SECONDARY_START: rd_word = ptr_reg[bus_ch]; // RULE5
                `DMA_OFS_PERIPH_ADDR: rd_word = pad_reg[bus_ch];
                `DMA_OFS_XFER_COUNT: rd_word = {6'h00, cnt_reg[bus_ch]}; // RULE10
                default: rd_word = 16'h0000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 16'h0000;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_word : 16'h0000;
        end
    end

    // Transfer strobe toward RAM and peripheral side, plus block done pulses
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            xfer_valid_o <= 1'b0;
            xfer_chan_o <= 3'h0;
            xfer_ram_addr_o <= 16'h0000;
            xfer_periph_addr_o <= 16'h0000;
            xfer_ram_to_periph_o <= 1'b0;
            xfer_byte_o <= 1'b0;
            block_done_o <= '0;
        end else begin
            xfer_valid_o <= do_xfer; // RULE1 RULE3
            block_done_o <= '0;
            if (do_xfer) begin
                xfer_chan_o <= xfer_ch;
                xfer_ram_addr_o <= ptr_reg[xfer_ch]; // RULE6 RULE7
                xfer_periph_addr_o <= pad_reg[xfer_ch]; // RULE8
                xfer_ram_to_periph_o <= cur_con[`DMA_CON_DIR_BIT]; // RULE16
                xfer_byte_o <= cur_con[`DMA_CON_BYTE_BIT];
                block_done_o[xfer_ch] <= blk_end; // RULE18
            end
        end
    end
endmodule // dma_channel_setup_regs
`default_nettype wire

// file: dv/dma_far_side_model.sv
// Far-side model: peripheral request lines and write-collision sources
`timescale 1ns/1ps
`default_nettype none
module dma_far_side_model (
    input wire logic sys_clk_i,
    input wire logic fire_i,
    input wire logic [6:0] line_i,
    input wire logic [7:0] pcol_i,
    input wire logic [7:0] rcol_i,
    output logic [127:0] source_request_lines_o,
    output logic [7:0] periph_collision_o,
    output logic [7:0] ram_collision_o
);
    logic [1:0] hold_reg = 2'h0;
    logic [6:0] sel_reg = 7'h00;
    // Request held two cycles then dropped, so each request is a fresh edge
    always @(posedge sys_clk_i) begin
        hold_reg <= fire_i ? 2'h2 : (hold_reg != 2'h0 ? hold_reg - 2'h1 : 2'h0);
        if (fire_i) begin
            sel_reg <= line_i;
        end
    end
    assign source_request_lines_o = (hold_reg != 2'h0) ? (128'h1 << sel_reg) : 128'h0;
    // Collision strobes pass straight through from the bench
    assign periph_collision_o = pcol_i;
    assign ram_collision_o = rcol_i;
endmodule // dma_far_side_model
`default_nettype wire

// file: dv/dma_channel_setup_regs_monitor.sv
// Port-level checker for the DMA channel setup block
`timescale 1ns/1ps
`default_nettype none
module dma_setup_monitor #(
    parameter int NUM_CH = 8
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [NUM_CH-1:0] periph_collision_i,
    input wire logic [NUM_CH-1:0] ram_collision_i,
    input wire logic xfer_valid_o,
    input wire logic [2:0] xfer_chan_o,
    input wire logic [15:0] xfer_ram_addr_o,
    input wire logic [15:0] xfer_periph_addr_o,
    input wire logic [NUM_CH-1:0] block_done_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // Channel-window and status-word access decodes
    wire ch_acc = !reg_addr_i[6];
    wire st_rd = reg_rd_i && reg_addr_i == 7'h40;
    a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_req_unused_zero: assert property (reg_rd_i && ch_acc && reg_addr_i[2:0] == 3'h1 |=> reg_rdata_o[14:7] == 8'h00)
        else $error("unused select bits not zero");
    a_cnt_unused_zero: assert property (reg_rd_i && ch_acc && reg_addr_i[2:0] == 3'h5 |=> reg_rdata_o[15:10] == 6'h00)
        else $error("unused count bits not zero");
    a_periph_addr_kept: assert property (reg_wr_i && ch_acc && reg_addr_i[2:0] == 3'h4 ##1 reg_rd_i && reg_addr_i == $past(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("peripheral address readback wrong");
    a_req_line_kept: assert property (reg_wr_i && ch_acc && reg_addr_i[2:0] == 3'h1 ##1 reg_rd_i && reg_addr_i == $past(reg_addr_i) |=> reg_rdata_o[6:0] == $past(reg_wdata_i[6:0], 2))
        else $error("line select readback wrong");
    a_pcol_sets_flag: assert property ((periph_collision_i != 0) ##1 st_rd |=> (reg_rdata_o[15:8] & $past(periph_collision_i, 2)) == $past(periph_collision_i, 2))
        else $error("peripheral collision flag not set");
    a_rcol_sets_flag: assert property ((ram_collision_i != 0) ##1 st_rd |=> (reg_rdata_o[7:0] & $past(ram_collision_i, 2)) == $past(ram_collision_i, 2))
        else $error("ram collision flag not set");
    a_done_with_xfer: assert property (|block_done_o |-> xfer_valid_o && block_done_o == (NUM_CH'(1) << xfer_chan_o))
        else $error("block end not on its channel transfer");
    a_xfer_addr_hold: assert property (!xfer_valid_o |-> $stable(xfer_ram_addr_o) && $stable(xfer_periph_addr_o))
        else $error("transfer address moved without transfer");
    c_xfer: cover property (xfer_valid_o);
    c_done: cover property (|block_done_o);
    c_status: cover property (st_rd);
endmodule // dma_setup_monitor
bind dma_channel_setup_regs dma_setup_monitor #(.NUM_CH(NUM_CH)) i_mon (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .periph_collision_i(periph_collision_i), .ram_collision_i(ram_collision_i),
    .xfer_valid_o(xfer_valid_o), .xfer_chan_o(xfer_chan_o), .xfer_ram_addr_o(xfer_ram_addr_o),
    .xfer_periph_addr_o(xfer_periph_addr_o), .block_done_o(block_done_o));
`default_nettype wire

// file: dv/dma_channel_setup_regs_tb.sv
// Self-checking bench for the DMA channel setup block
`timescale 1ns/1ps
`default_nettype none
module dma_channel_setup_regs_tb import dma_setup_pkg::*;;
    typedef struct {logic [6:0] a; word_t d; word_t e;} row_s;
    logic sys_clk_i = 1'b0, srst_i = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0, dir, xv, xb;
    logic [6:0] addr = 7'h00, line = 7'h00;
    logic [7:0] pcol = 8'h00, rcol = 8'h00, pc, rc, done;
    logic [127:0] req;
    logic [2:0] xch;
    word_t wdata = 16'h0000, rdata, xra, xpa, last_ra, last_pa, got;
    int n_mismatch = 0, n_tests = 0, n_xfer = 0, n_done0 = 0, n_done2 = 0, i;
    // Ordinary register cases: write, settle, read back
    row_s rows[8] = '{'{7'h0c, 16'hbeef, 16'hbeef}, '{7'h0d, 16'hffff, 16'h03ff},
        '{7'h09, 16'h7fff, 16'h007f}, '{7'h08, 16'h7fff, 16'h7833}, '{7'h0a, 16'h1234, 16'h1234},
        '{7'h0b, 16'h5678, 16'h1234}, '{7'h0e, 16'hffff, 16'h0000}, '{7'h41, 16'hffff, 16'h0000}};
    always #2.5 sys_clk_i = ~sys_clk_i;
    dma_channel_setup_regs i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .source_request_lines_i(req), .periph_collision_i(pc), .ram_collision_i(rc),
        .xfer_valid_o(xv), .xfer_chan_o(xch), .xfer_ram_addr_o(xra), .xfer_periph_addr_o(xpa),
        .xfer_ram_to_periph_o(dir), .xfer_byte_o(xb), .block_done_o(done));
    dma_far_side_model i_far (.sys_clk_i(sys_clk_i), .fire_i(fire), .line_i(line),
        .pcol_i(pcol), .rcol_i(rcol), .source_request_lines_o(req),
        .periph_collision_o(pc), .ram_collision_o(rc));
    // Transfer log kept apart from the stimulus
    always @(posedge sys_clk_i) begin
        if (xv === 1'b1) begin
            n_xfer++;
            last_ra = xra;
            last_pa = xpa;
        end
        n_done0 += (done[0] === 1'b1);
        n_done2 += (done[2] === 1'b1);
    end
    task automatic chk(input word_t g, input word_t e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Idle edge after each write keeps the strobes of two calls apart
    task automatic wr_reg(input logic [6:0] a, input word_t d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i) wr <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    // Write, then read the same word straight after it
    task automatic wr_rd(input logic [6:0] a, input word_t d, input word_t e);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge sys_clk_i) rd <= 1'b0;
        @(negedge sys_clk_i) got = rdata;
        @(posedge sys_clk_i) chk(got, e);
    endtask
    task automatic rd_chk(input logic [6:0] a, input word_t e);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i) rd <= 1'b0;
        @(negedge sys_clk_i) got = rdata;
        @(posedge sys_clk_i) chk(got, e);
    endtask
    task automatic pulse(input logic [6:0] n);
        fire <= 1'b1;
        line <= n;
        @(posedge sys_clk_i) fire <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic wait_xfer(input int n);
        for (int k = 0; k < 60 && n_xfer < n; k++) @(posedge sys_clk_i);
        if (n_xfer < n) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd_chk(7'h0d, 16'h0000);
        rd_chk(7'h40, 16'h0000);
        foreach (rows[r]) begin
            wr_reg(rows[r].a, rows[r].d);
            repeat (3) @(posedge sys_clk_i);
            rd_chk(rows[r].a, rows[r].e);
        end
        // Forced one-shot block of three; addresses and count written while disabled, request select rewritten while enabled
        wr_reg(7'h02, 16'h0100);
        wr_rd(7'h04, 16'h0300, 16'h0300);
        wr_reg(7'h05, 16'h0002);
        // Force set while disabled; a write of zero must not clear it
        wr_reg(7'h01, 16'h8000);
        wr_rd(7'h01, 16'h0000, 16'h8000);
        wr_reg(7'h00, 16'ha001);
        repeat (4) @(posedge sys_clk_i);
        for (i = 0; i < 3; i++) begin
            if (i > 0) wr_reg(7'h01, 16'h8000);
            wait_xfer(i + 1);
            chk(last_ra, 16'h0100 + 16'(2 * i));
            chk(last_pa, 16'h0300);
            chk({12'h000, xb, xch}, 16'h0000);
            chk({15'h0000, dir}, 16'h0001);
        end
        repeat (10) @(posedge sys_clk_i);
        chk(16'(n_xfer), 16'h0003);
        chk(16'(n_done0), 16'h0001);
        rd_chk(7'h01, 16'h0000);
        rd_chk(7'h00, 16'h2001);
        // Continuous single-transfer blocks on request line five
        wr_reg(7'h12, 16'h0200);
        wr_reg(7'h15, 16'h0000);
        wr_rd(7'h11, 16'h0005, 16'h0005);
        wr_reg(7'h10, 16'h8000);
        repeat (4) @(posedge sys_clk_i);
        pulse(7'h06);
        repeat (8) @(posedge sys_clk_i);
        chk(16'(n_xfer), 16'h0003);
        for (i = 0; i < 2; i++) begin
            pulse(7'h05);
            wait_xfer(4 + i);
            chk(last_ra, 16'h0200);
            chk({12'h000, xb, xch}, 16'h0002);
            chk({15'h0000, dir}, 16'h0000);
        end
        chk(16'(n_done2), 16'h0002);
        // One-shot ping-pong on channel 3, byte steps, two transfers per buffer
        wr_reg(7'h1a, 16'h0400);
        wr_reg(7'h1b, 16'h0500);
        wr_reg(7'h1d, 16'h0001);
        wr_reg(7'h18, 16'hc003);
        repeat (4) @(posedge sys_clk_i);
        for (i = 0; i < 4; i++) begin
            wr_reg(7'h19, 16'h8000);
            wait_xfer(6 + i);
            chk(last_ra, 16'h0400 + 16'(256 * (i / 2)) + 16'(i % 2));
            chk({12'h000, xb, xch}, 16'h000b);
        end
        rd_chk(7'h18, 16'h4003);
        // Collision flags: set, read at once, partial clear
        pcol <= 8'h08;
        rcol <= 8'h40;
        @(posedge sys_clk_i) begin
            pcol <= 8'h00;
            rcol <= 8'h00;
        end
        rd_chk(7'h40, 16'h0840);
        wr_reg(7'h40, 16'hf7ff);
        rd_chk(7'h40, 16'h0040);
        end_of_test();
    end
endmodule // dma_channel_setup_regs_tb
`default_nettype wire
